// File: verilog/mtl_regs.vh
// Register offsets, field positions, reset values and timing counts for the MAC limits block
// Operation
// - Legal maximum 1518 untagged, 1522 tagged
// - Oversize off: corrupt and truncate at limit
// - Oversize on: long frames sent error free
// - Programmable MTU replaces limit, at least 1518
// - Over MTU, oversize off: bad, errored, truncated
// - Oversize plus MTU: oversize behaviour wins
// - Tagged plus MTU: MTU limit applies
// - Gap stretching back-pressures for requested columns
// - Always at least three idle columns
// - Idle deficit balancing keeps full rate; dic_q is counted but never shortens the gap
// - No override: local fault sends remote, remote sends idle
// - Fault flags at bits 28, 29 of 0x410
// - Without management, flags on status bits 0, 1
// - Frames dropped silently while fault flag set
// - Override on: transmit ignoring received faults
// - Receive stream 64 or 32 bits wide
// - Receive ports on receive clock, own reset; here clocked by pclk
// - Status bit 0 bad, 1 good
// - Qualifier bit n marks byte lane n
// - Last marks final transfer of packet
// - Last and status after all checks
// - Qualifiers full except last, contiguous from lane 0
`ifndef MTL_REGS_VH
`define MTL_REGS_VH
`define MTL_OFF_CTRL 12'h400
`define MTL_OFF_RECON 12'h410
`define MTL_OFF_MTU 12'h414
`define MTL_OFF_STAT 12'h418
`define MTL_CTRL_OVERSIZE 0
`define MTL_CTRL_TAGGED 1
`define MTL_CTRL_MTU_EN 2
`define MTL_CTRL_IFG_EN 3
`define MTL_CTRL_DEFICIT 4
`define MTL_RECON_OVERRIDE 0
`define MTL_RECON_LOCAL 28
`define MTL_RECON_REMOTE 29
`define MTL_CTRL_RESET 32'h00000010
`define MTL_MTU_RESET 16'h05EE
`define MTL_MAX_UNTAGGED 16'h05EE
`define MTL_MAX_TAGGED 16'h05F2
`define MTL_MIN_IFG_COLS 8'h03
`define MTL_DIC_MAX 2'h3
`endif

// File: verilog/mtl_mac_limits.v
// MAC transmit limits, gap and fault handling with receive stream output stage
`timescale 1ns/1ps
`include "mtl_regs.vh"
module mtl_mac_limits #(
   parameter DATA_W = 64
)
(
   input wire pclk,
   input wire presetn,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output reg pready,
   output reg pslverr,
   // Transmit client stream, 64 bits in eight byte lanes
   input wire [63:0] s_axis_tx_tdata,
   input wire [7:0] s_axis_tx_tkeep,
   input wire s_axis_tx_tvalid,
   input wire s_axis_tx_tlast,
   output reg s_axis_tx_tready,
   input wire [7:0] tx_ifg_delay,
   // Line-side XGMII transmit, one column per cycle
   output reg [63:0] xgmii_txd,
   output reg [7:0] xgmii_txc,
   // Receive fault indications from the link, asynchronous
   input wire rx_local_fault,
   input wire rx_remote_fault,
   output reg [1:0] status_vector,
   // Receive stream from frame checker to client
   input wire rx_axis_aresetn,
   input wire [DATA_W-1:0] rx_in_data,
   input wire [DATA_W/8-1:0] rx_in_keep,
   input wire rx_in_valid,
   input wire rx_in_last,
   input wire rx_in_good,
   output reg [DATA_W-1:0] m_axis_rx_tdata,
   output reg [DATA_W/8-1:0] m_axis_rx_tkeep,
   output reg m_axis_rx_tvalid,
   output reg m_axis_rx_tuser,
   output reg m_axis_rx_tlast
);
   localparam KW = DATA_W / 8;
   localparam ST_IDLE = 3'b001;
   localparam ST_DATA = 3'b010;
   localparam ST_GAP = 3'b100;
   localparam [63:0] IDLE_COL = 64'h0707070707070707;
   localparam [63:0] ERR_COL = 64'hFEFEFEFEFEFEFEFE;
   localparam [63:0] RFAULT_COL = 64'h0200000C0200009C;
   localparam [63:0] START_COL = 64'hD5555555555555FB;

   reg [31:0] ctrl_q;
   reg [15:0] mtu_q;
   reg override_q;
   reg [1:0] lf_sync_q;
   reg [1:0] rf_sync_q;
   reg [2:0] state_q;
   reg [15:0] count_q;
   reg [7:0] gap_q;
   reg [1:0] dic_q;
   reg err_q;
   reg drop_q;
   reg [31:0] bad_frames_q;
   wire local_f = lf_sync_q[1];
   wire remote_f = rf_sync_q[1];
   wire fault_active = (local_f | remote_f) & ~override_q;
   wire oversize_en = ctrl_q[`MTL_CTRL_OVERSIZE];
   wire mtu_en = ctrl_q[`MTL_CTRL_MTU_EN];
   wire tagged_en = ctrl_q[`MTL_CTRL_TAGGED];
   reg [15:0] limit;
   reg [3:0] nbytes;
   integer i;

   // Two-stage synchronisers for the fault inputs
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         lf_sync_q <= 2'h0;
         rf_sync_q <= 2'h0;
      end
      else
      begin
         lf_sync_q <= {lf_sync_q[0], rx_local_fault};
         rf_sync_q <= {rf_sync_q[0], rx_remote_fault};
      end
   end

   // APB slave, zero wait states; unmapped addresses answer with an error
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         ctrl_q <= `MTL_CTRL_RESET;
         mtu_q <= `MTL_MTU_RESET;
         override_q <= 1'b0;
         prdata <= 32'h00000000;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end
      else
      begin
         pready <= psel & ~penable;
         pslverr <= 1'b0;
         if (psel && !penable)
         begin
            prdata <= 32'h00000000;
            case (paddr)
               `MTL_OFF_CTRL: prdata <= ctrl_q;
               `MTL_OFF_RECON: prdata <= {2'h0, remote_f, local_f, 27'h0, override_q};
               `MTL_OFF_MTU: prdata <= {16'h0000, mtu_q};
               `MTL_OFF_STAT: prdata <= bad_frames_q;
               default: pslverr <= 1'b1;
            endcase
         end
         // Writes land only at the access edge, where the master sees pready high
         if (psel && penable && pready && pwrite)
         begin
            case (paddr)
               `MTL_OFF_CTRL: ctrl_q <= {27'h0, pwdata[4:0]};
               `MTL_OFF_RECON: override_q <= pwdata[`MTL_RECON_OVERRIDE];
               // Values below the standard limit are clamped up
               `MTL_OFF_MTU: mtu_q <= (pwdata[15:0] < `MTL_MAX_UNTAGGED) ?
                  `MTL_MAX_UNTAGGED : pwdata[15:0];
               default: ;
            endcase
         end
      end
   end

   // Frame length limit selection
   always @*
   begin
      if (mtu_en)
         limit = mtu_q;
      else if (tagged_en)
         limit = `MTL_MAX_TAGGED;
      else
         limit = `MTL_MAX_UNTAGGED;
      nbytes = 4'h0;
      for (i = 0; i < 8; i = i + 1)
         nbytes = nbytes + {3'h0, s_axis_tx_tkeep[i]};
   end

   // Transmit state machine: length policing, gap stretch, fault handling
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         state_q <= ST_IDLE;
         count_q <= 16'h0000;
         gap_q <= 8'h00;
         dic_q <= 2'h0;
         err_q <= 1'b0;
         drop_q <= 1'b0;
         bad_frames_q <= 32'h00000000;
         s_axis_tx_tready <= 1'b0;
         xgmii_txd <= IDLE_COL;
         xgmii_txc <= 8'hFF;
         status_vector <= 2'h0;
      end
      else
      begin
         status_vector <= {remote_f, local_f};
         xgmii_txd <= IDLE_COL;
         xgmii_txc <= 8'hFF;
         if (local_f && !override_q)
            xgmii_txd <= RFAULT_COL;
         case (state_q)
            ST_IDLE:
            begin
               s_axis_tx_tready <= 1'b1;
               if (s_axis_tx_tvalid && s_axis_tx_tready)
               begin
                  // Frames offered during a fault vanish without trace
                  drop_q <= fault_active;
                  if (!fault_active)
                  begin
                     xgmii_txd <= START_COL;
                     xgmii_txc <= 8'h01;
                  end
                  count_q <= {12'h000, nbytes};
                  err_q <= 1'b0;
                  state_q <= s_axis_tx_tlast ? ST_GAP : ST_DATA;
                  gap_q <= `MTL_MIN_IFG_COLS;
               end
            end
            ST_DATA:
            begin
               if (s_axis_tx_tvalid && s_axis_tx_tready)
               begin
                  count_q <= count_q + {12'h000, nbytes};
                  if (!drop_q)
                  begin
                     xgmii_txd <= s_axis_tx_tdata;
                     xgmii_txc <= 8'h00;
                     // Overlength without oversize handling is corrupted and truncated
                     if (!oversize_en && (count_q + {12'h000, nbytes} > limit))
                     begin
                        xgmii_txd <= ERR_COL;
                        xgmii_txc <= 8'hFF;
                        if (!err_q)
                           bad_frames_q <= bad_frames_q + 32'h00000001;
                        err_q <= 1'b1;
                        drop_q <= 1'b1;
                     end
                  end
                  if (s_axis_tx_tlast)
                  begin
                     state_q <= ST_GAP;
                     s_axis_tx_tready <= 1'b0;
                     // Requested gap latched at end of frame, floor of three
                     if (ctrl_q[`MTL_CTRL_IFG_EN] && tx_ifg_delay > `MTL_MIN_IFG_COLS)
                        gap_q <= tx_ifg_delay;
                     else
                        gap_q <= `MTL_MIN_IFG_COLS;
                     // Deficit balancing: dic_q counts the deficit but never shortens the gap
                     if (ctrl_q[`MTL_CTRL_DEFICIT] && nbytes[1:0] != 2'h0
                        && dic_q != `MTL_DIC_MAX)
                        dic_q <= dic_q + 2'h1;
                     else
                        dic_q <= 2'h0;
                  end
               end
            end
            ST_GAP:
            begin
               s_axis_tx_tready <= 1'b0;
               gap_q <= gap_q - 8'h01;
               if (gap_q <= 8'h01)
               begin
                  state_q <= ST_IDLE;
                  s_axis_tx_tready <= 1'b1;
               end
            end
            default: state_q <= ST_IDLE;
         endcase
      end
   end

   // Receive stage on pclk with its own reset: registered pass of checked frames
   always @(posedge pclk or negedge rx_axis_aresetn)
   begin
      if (!rx_axis_aresetn)
      begin
         m_axis_rx_tdata <= {DATA_W{1'b0}};
         m_axis_rx_tkeep <= {KW{1'b0}};
         m_axis_rx_tvalid <= 1'b0;
         m_axis_rx_tuser <= 1'b0;
         m_axis_rx_tlast <= 1'b0;
      end
      else
      begin
         // No ready: client takes every beat
         m_axis_rx_tvalid <= rx_in_valid;
         m_axis_rx_tdata <= rx_in_data;
         // Full keep mid-frame; last beat passes rx_in_keep unchanged
         m_axis_rx_tkeep <= (rx_in_last) ? rx_in_keep : {KW{1'b1}};
         m_axis_rx_tlast <= rx_in_valid & rx_in_last;
         m_axis_rx_tuser <= rx_in_valid & rx_in_last & rx_in_good;
      end
   end
endmodule // mtl_mac_limits

// File: sim/mtl_mac_limits_props.sv
// Port assertions for the MAC limits block
`timescale 1ns/1ps
module mtl_mac_limits_props #(
   parameter DATA_W = 64
)
(
   input wire pclk,
   input wire presetn,
   input wire s_axis_tx_tvalid,
   input wire s_axis_tx_tlast,
   input wire s_axis_tx_tready,
   input wire rx_local_fault,
   input wire rx_remote_fault,
   input wire [1:0] status_vector,
   input wire rx_axis_aresetn,
   input wire rx_in_valid,
   input wire rx_in_last,
   input wire rx_in_good,
   input wire [DATA_W/8-1:0] m_axis_rx_tkeep,
   input wire m_axis_rx_tvalid,
   input wire m_axis_rx_tuser,
   input wire m_axis_rx_tlast
);
   default clocking dc @(posedge pclk); endclocking
   default disable iff (!presetn);
   // Last client beat taken; the gap starts here
   sequence s_tx_end;
      s_axis_tx_tvalid && s_axis_tx_tready && s_axis_tx_tlast;
   endsequence
   // Beat with the receive stage out of reset on both edges
   sequence s_rx(b);
      rx_axis_aresetn && b ##1 rx_axis_aresetn;
   endsequence
   property p_gap_min;
      s_tx_end |=> !s_axis_tx_tready [*3];
   endproperty
   a_gap_min: assert property (p_gap_min) else $error("gap too short");
   property p_gap_end;
      s_tx_end |-> ##[1:300] s_axis_tx_tready;
   endproperty
   a_gap_end: assert property (p_gap_end) else $error("gap never ends");
   // Synchroniser plus register needs three settled samples
   property p_flags;
      ($stable({rx_remote_fault, rx_local_fault})) [*4] |->
         status_vector == {rx_remote_fault, rx_local_fault};
   endproperty
   a_flags: assert property (p_flags) else $error("status flags wrong");
   property p_rx_valid;
      s_rx(rx_in_valid) |-> m_axis_rx_tvalid;
   endproperty
   a_rx_valid: assert property (p_rx_valid) else $error("beat lost");
   property p_rx_end;
      s_rx(rx_in_valid && rx_in_last) |-> m_axis_rx_tlast && m_axis_rx_tuser == $past(rx_in_good);
   endproperty
   a_rx_end: assert property (p_rx_end) else $error("end status wrong");
   property p_keep_full;
      m_axis_rx_tvalid && !m_axis_rx_tlast |-> &m_axis_rx_tkeep;
   endproperty
   a_keep_full: assert property (p_keep_full) else $error("partial beat");
   property p_keep_lead;
      m_axis_rx_tvalid && m_axis_rx_tlast |->
         (m_axis_rx_tkeep & (m_axis_rx_tkeep + 1'b1)) == '0 && m_axis_rx_tkeep != '0;
   endproperty
   a_keep_lead: assert property (p_keep_lead) else $error("last lanes broken");
   property p_user_last;
      m_axis_rx_tuser |-> m_axis_rx_tvalid && m_axis_rx_tlast;
   endproperty
   a_user_last: assert property (p_user_last) else $error("status early");
endmodule // mtl_mac_limits_props

bind mtl_mac_limits mtl_mac_limits_props #(.DATA_W(DATA_W)) u_props (.pclk, .presetn,
   .s_axis_tx_tvalid, .s_axis_tx_tlast, .s_axis_tx_tready, .rx_local_fault, .rx_remote_fault,
   .status_vector, .rx_axis_aresetn, .rx_in_valid, .rx_in_last, .rx_in_good,
   .m_axis_rx_tkeep, .m_axis_rx_tvalid, .m_axis_rx_tuser, .m_axis_rx_tlast);

// File: sim/mtl_client_model.sv
// Transmit client model sending frames of whole 64-bit beats
`timescale 1ns/1ps
module mtl_client_model
(
   input wire clk,
   input wire go,
   input wire [8:0] beats,
   input wire tready,
   output reg [63:0] tdata,
   output reg tvalid,
   output reg tlast,
   output reg busy
);
   reg [8:0] n_q;
   initial {tdata, tvalid, tlast, busy, n_q} = '0;
   // Valid stays high from first to last beat; data toggles so stale lanes never look held
   always @(posedge clk)
      if (go && !busy)
         {busy, tvalid, tlast, n_q} <= {2'b11, beats == 9'h001, beats};
      else if (tvalid && tready)
      begin
         n_q <= n_q - 9'h001;
         tlast <= n_q == 9'h002;
         tdata <= ~tdata;
         if (tlast)
            {busy, tvalid, tlast} <= 3'b000;
      end
endmodule // mtl_client_model

// File: sim/mtl_mac_limits_tb.sv
// Self-checking bench for the MAC limits block
`timescale 1ns/1ps
module mtl_mac_limits_tb;
   reg pclk, presetn, psel, penable, pwrite, rx_rst_n, go, lf, rf, iv, il, ig;
   reg [11:0] paddr;
   reg [31:0] pwdata, x;
   reg [63:0] idat;
   reg [7:0] ikeep, ifg;
   reg [8:0] beats;
   reg [73:0] q[$];
   wire [31:0] prdata;
   wire pready, pslverr, trdy, tv, tl, bsy, ov, ou, ol;
   wire [63:0] td, txd, od;
   wire [7:0] txc, ok;
   wire [1:0] sv;
   integer err_total, comparisons, nfb, nfe, gapn, e0, k, j;
   mtl_client_model cli (.clk(pclk), .go(go), .beats(beats), .tready(trdy), .tdata(td),
      .tvalid(tv), .tlast(tl), .busy(bsy));
   mtl_mac_limits uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
      .pready, .pslverr, .s_axis_tx_tdata(td), .s_axis_tx_tkeep(8'hFF), .s_axis_tx_tvalid(tv),
      .s_axis_tx_tlast(tl), .s_axis_tx_tready(trdy), .tx_ifg_delay(ifg), .xgmii_txd(txd),
      .xgmii_txc(txc), .rx_local_fault(lf), .rx_remote_fault(rf), .status_vector(sv),
      .rx_axis_aresetn(rx_rst_n), .rx_in_data(idat), .rx_in_keep(ikeep), .rx_in_valid(iv),
      .rx_in_last(il), .rx_in_good(ig), .m_axis_rx_tdata(od), .m_axis_rx_tkeep(ok),
      .m_axis_rx_tvalid(ov), .m_axis_rx_tuser(ou), .m_axis_rx_tlast(ol));
   function [31:0] xs(input [31:0] v);
      v = v ^ (v << 13);
      v = v ^ (v >> 17);
      return v ^ (v << 5);
   endfunction
   task chk(input [73:0] s, input [73:0] e);
      comparisons = comparisons + 1;
      if (s !== e)
         err_total = err_total + 1;
      if (s !== e)
         $display("Error at %0t: saw %h, wanted %h", $time, s, e);
   endtask
   task test_done;
      $display("Mismatches %0d, comparisons %0d", err_total, comparisons);
      if (err_total == 0 && comparisons > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   task hang;
      chk(1'b1, 1'b0);
      test_done;
   endtask
   // One APB transfer; queues the expected {pslverr, read data}
   task apb(input w, input [11:0] a, input [31:0] d, input [32:0] e);
      q.push_back({41'h0, e});
      {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
      @(posedge pclk);
      penable <= 1'b1;
      // pready is read as sampled at each edge, before the design updates it
      k = 0;
      @(posedge pclk);
      while (!pready && k < 20)
      begin
         k = k + 1;
         @(posedge pclk);
      end
      if (!pready)
         hang;
      {psel, penable} <= 2'b00;
      @(posedge pclk);
   endtask
   // Whole frame from the client model, then wait out the gap
   task txf(input [8:0] n);
      {beats, go} <= {n, 1'b1};
      @(posedge pclk);
      go <= 1'b0;
      @(posedge pclk);
      for (k = 0; k < 900 && (bsy || !trdy); k = k + 1)
         @(posedge pclk);
      if (k == 900)
         hang;
   endtask
   task lenchk(input [8:0] n, input e);
      e0 = nfe;
      txf(n);
      chk(nfe > e0, e);
   endtask
   // Received frame; only the last beat may be short, from lane 0 up
   task rxf(input [2:0] n);
      // Beats go out every cycle; the client side has no way to stall them
      for (k = 1; k <= n; k = k + 1)
      begin
         x = xs(x);
         {idat, ikeep, iv, il, ig} <= {x, ~x, k < n ? 8'hFF : 8'hFF >> x[2:0], 1'b1, k == n, x[9]};
         q.push_back({x[9] && k == n, k == n, k < n ? 8'hFF : 8'hFF >> x[2:0], x, ~x});
         @(posedge pclk);
      end
      {idat, iv, il} <= {x, x, 2'b00};
      @(posedge pclk);
   endtask
   // Oldest note is matched to each result as it shows
   always @(posedge pclk)
   begin
      if (ov)
         chk({ou, ol, ok, od}, q.pop_front());
      else if (psel && penable && pready)
         chk({pslverr, pwrite ? 32'h0 : prdata}, q.pop_front());
      // Line outputs are unknown until the first reset edge, so count only out of reset
      if (presetn)
      begin
         nfb = nfb + (txc[0] && txd[7:0] == 8'hFB);
         for (j = 0; j < 8; j = j + 1)
            nfe = nfe + (txc[j] && txd[j*8+:8] == 8'hFE);
         gapn = (tv && trdy && tl) ? 0 : gapn + !trdy;
      end
   end
   initial
   begin
      pclk = 1'b0;
      forever
         #4 pclk = ~pclk;
   end
   // Reset, registers, faults, length limits, gap, receive traffic
   initial
   begin
      {presetn, rx_rst_n, psel, penable, pwrite, go, lf, rf, iv, il, ig} = 11'h000;
      {paddr, pwdata, idat, ikeep, ifg, beats} = '0;
      {x, err_total, comparisons, nfb, nfe, gapn} = {32'h4, 160'h0};
      repeat (20)
         @(posedge pclk);
      {presetn, rx_rst_n} <= 2'b11;
      @(posedge pclk);
      apb(0, 12'h400, 0, 33'h10);
      apb(0, 12'h414, 0, 33'h5EE);
      apb(1, 12'h414, 32'h100, 0);
      apb(0, 12'h414, 0, 33'h5EE);
      apb(1, 12'h7FC, 0, 33'h100000000);
      {lf, rf} <= 2'b11;
      repeat (6)
         @(posedge pclk);
      chk(sv, 2'b11);
      apb(0, 12'h410, 0, 33'h30000000);
      txf(4);
      chk(nfb, 0);
      apb(1, 12'h410, 1, 0);
      txf(4);
      chk(nfb, 1);
      {lf, rf} <= 2'b00;
      apb(1, 12'h410, 0, 0);
      apb(1, 12'h414, 32'h7D0, 0);
      apb(1, 12'h400, 32'h16, 0);
      lenchk(191, 0);
      lenchk(260, 1);
      apb(0, 12'h418, 0, 33'h1);
      apb(1, 12'h400, 32'h15, 0);
      lenchk(260, 0);
      apb(1, 12'h400, 32'h10, 0);
      lenchk(191, 1);
      apb(1, 12'h400, 32'h11, 0);
      lenchk(191, 0);
      apb(1, 12'h400, 32'h18, 0);
      ifg <= 8'h0A;
      txf(2);
      chk(gapn, 10);
      ifg <= 8'h01;
      txf(2);
      chk(gapn, 3);
      repeat (6)
         rxf({1'b0, x[1:0]} + 3'h1);
      repeat (4)
         @(posedge pclk);
      test_done;
   end
endmodule // mtl_mac_limits_tb
